// ---- pkg/usp_pkg.sv ----
// shared constants, register layouts and carriers for the uart channel
package usp_pkg;

  localparam int unsigned FRAME_W = 13;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_TXBUF = 8'h00;
  localparam logic [7:0] OFS_RXBUF = 8'h04;
  localparam logic [7:0] OFS_BRG   = 8'h08;
  localparam logic [7:0] OFS_MODE  = 8'h0C;
  localparam logic [7:0] OFS_CTL0  = 8'h10;
  localparam logic [7:0] OFS_CTL1  = 8'h14;
  localparam logic [7:0] OFS_ROUTE = 8'h18;

  // ----------------------------------------------------------------
  // codes
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_7BIT = 3'h4;
  localparam logic [2:0] MODE_8BIT = 3'h5;
  localparam logic [2:0] MODE_9BIT = 3'h6;
  localparam logic [1:0] CS_F1     = 2'h0;
  localparam logic [1:0] CS_F8     = 2'h1;
  localparam logic [1:0] CS_F32    = 2'h2;
  localparam logic [1:0] ROUTE_OFF = 2'h0;
  localparam logic [2:0] PRE8_LAST  = 3'h7;
  localparam logic [4:0] PRE32_LAST = 5'h1F;
  localparam logic [3:0] OVS_LAST   = 4'hF;
  localparam logic [3:0] SAMPLE_PT  = 4'h7;
  localparam logic [3:0] LEN_7  = 4'h7;
  localparam logic [3:0] LEN_8  = 4'h8;
  localparam logic [3:0] LEN_9  = 4'h9;

  // ----------------------------------------------------------------
  // register layouts
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       rsv7;
    logic       parity_enable;
    logic       parity_odd_even;      // 1 = even
    logic       stop_bit_count;       // 1 = two stop bits
    logic       bit_clock_source_sel; // 1 = external
    logic [2:0] serial_mode_field;
  } usp_mode_s;

  typedef struct packed {
    logic       bit_order_select;     // 1 = msb first
    logic       clock_polarity_select;
    logic       open_drain_select;
    logic       rsv4;
    logic       shift_reg_empty_flag;
    logic       rsv2;
    logic [1:0] divider_count_source;
  } usp_ctl0_s;

  typedef struct packed {
    logic [1:0] rsv;
    logic       continuous_rx_mode;
    logic       tx_irq_source_select; // 1 = shift-out complete
    logic       rx_complete;
    logic       rx_enable;
    logic       tx_buffer_empty;
    logic       tx_enable;
  } usp_ctl1_s;

  typedef struct packed {
    logic [1:0] rsv;
    logic [1:0] clock_sel;
    logic [1:0] in_sel;
    logic [1:0] out_sel;
  } usp_route_s;

  typedef struct packed {
    logic       sum;
    logic       parity_error_flag;
    logic       framing_error_flag;
    logic       overrun_flag;
    logic [2:0] rsv;
    logic [8:0] data;
  } usp_rxbuf_s;

  typedef struct packed {
    logic [FRAME_W-1:0] bits;
    logic [3:0]         len;
  } usp_frame_s;

  localparam usp_mode_s  RST_MODE  = 8'h00;
  localparam usp_ctl0_s  RST_CTL0  = 8'h08;
  localparam usp_ctl1_s  RST_CTL1  = 8'h02;
  localparam usp_route_s RST_ROUTE = 8'h00;

endpackage : usp_pkg

// ---- logic/usp_tx.sv ----
// transmit shifter: sends a prebuilt frame lsb first, sixteen ticks per bit
`timescale 1ns/1ns
`default_nettype none
module usp_tx
  import usp_pkg::*;
(
  input  wire logic       clk,     // system clock
  input  wire logic       rst_n,   // async reset, active low
  input  wire logic       tick16,  // sixteen times bit rate enable
  input  wire logic       start,   // load frame when idle
  input  wire usp_frame_s frame,   // frame bits and length
  output logic            line,    // serial level, idle high
  output logic            busy,    // frame in progress
  output logic            done     // pulse after last stop bit
);

  typedef struct packed {
    logic [FRAME_W-1:0] sh;
    logic [3:0]         left;
    logic [3:0]         sub;
    logic               busy;
    logic               line;
    logic               done;
  } usp_tx_s;

  usp_tx_s q;
  usp_tx_s d;

  always_comb
  begin
    d = q;
    d.done = 1'b0;
    if (!q.busy)
    begin
      if (start)
      begin
        d.sh   = frame.bits;
        d.left = frame.len;
        d.sub  = 4'h0;
        d.busy = 1'b1;
        d.line = frame.bits[0];
      end
    end
    else if (tick16)
    begin
      if (q.sub == OVS_LAST)
      begin
        d.sub = 4'h0;
        if (q.left == 4'h1)
        begin
          d.busy = 1'b0;
          d.line = 1'b1;
          d.done = 1'b1;
        end
        else
        begin
          d.left = q.left - 4'h1;
          d.sh   = {1'b1, q.sh[FRAME_W-1:1]};
          d.line = q.sh[1];
        end
      end
      else
        d.sub = q.sub + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= '{sh: '1, left: 4'h0, sub: 4'h0, busy: 1'b0, line: 1'b1, done: 1'b0};
    else
      q <= d;
  end

  assign line = q.line;
  assign busy = q.busy;
  assign done = q.done;

endmodule : usp_tx
`default_nettype wire

// ---- logic/usp_rx.sv ----
// receive sampler: finds the start bit and samples each bit at mid point
`timescale 1ns/1ns
`default_nettype none
module usp_rx
  import usp_pkg::*;
(
  input  wire logic               clk,     // system clock
  input  wire logic               rst_n,   // async reset, active low
  input  wire logic               tick16,  // sixteen times bit rate enable
  input  wire logic               enable,  // receiver on
  input  wire logic               line_in, // serial level
  input  wire logic [3:0]         len,     // bits after the start bit
  output logic [FRAME_W-1:0]      data,    // bits, last one at the top
  output logic                    done     // pulse at last stop sample
);

  typedef struct packed {
    logic [FRAME_W-1:0] sh;
    logic [3:0]         left;
    logic [3:0]         sub;
    logic               busy;
    logic               in_start;
    logic               prev;
    logic               done;
  } usp_rx_s;

  usp_rx_s q;
  usp_rx_s d;

  always_comb
  begin
    d = q;
    d.done = 1'b0;
    d.prev = line_in;
    if (!enable)
      d.busy = 1'b0;
    else if (!q.busy)
    begin
      if (q.prev && !line_in)
      begin
        d.busy     = 1'b1;
        d.in_start = 1'b1;
        d.sub      = 4'h0;
        d.left     = len;
      end
    end
    else if (tick16)
    begin
      d.sub = q.sub + 4'h1;
      if (q.sub == SAMPLE_PT)
      begin
        // a start bit that is gone by mid point was a glitch
        if (q.in_start)
        begin
          d.in_start = 1'b0;
          d.busy     = !line_in;
        end
        else
        begin
          d.sh   = {line_in, q.sh[FRAME_W-1:1]};
          d.left = q.left - 4'h1;
          if (q.left == 4'h1)
          begin
            d.busy = 1'b0;
            d.done = 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= '{sh: '0, left: 4'h0, sub: 4'h0, busy: 1'b0, in_start: 1'b0,
             prev: 1'b1, done: 1'b0};
    else
      q <= d;
  end

  assign data = q.sh;
  assign done = q.done;

endmodule : usp_rx
`default_nettype wire

// ---- logic/usp_uart.sv ----
// one asynchronous serial channel with ahb-lite registers and pin routing
//
// Added by the designer: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ns
`default_nettype none
// How it works
// - mode codes 100b, 101b, 110b give 7, 8, 9 bit characters.
// - bit order select picks lsb or msb first, 8-bit characters only.
// - buffers hold character in b0-b6, b0-b7 or b0-b8 by length.
// - unused high receive bits for 7 and 8 bit characters read as zero.
// - selected uart mode drives output high until first transfer.
// - open drain select leaves output released instead of driven high.
// - clock source select picks internal or external bit clock.
// - parity bits choose parity on or off, odd or even.
// - count source field picks prescaled clock feeding the divider.
// - shift register empty flag shows no frame is shifting.
// - transmit buffer empty flag shows buffer can take data.
// - transmission starts only with transmit enable set; a frame under way finishes.
// - reception runs only with receive enable set.
// - transmit request comes from buffer emptying or shift-out end.
// - channel 0 output pin used only when its select bit is 1.
// - channel 0 input used with select 1 and pin direction input.
// - channel 0 clock pin input needs select, external clock, input direction.
// - channel 1 output select 01b, 10b picks location, 00b none.
// - channel 1 input select 01b, 10b picks location, 00b none.
// - channel 1 clock select 01b, 10b, 11b picks location, external input.
// - bit rate is selected clock over 16 times divider plus one.
// - frame is start, character, optional parity, one or two stops.
// - transmit starts when enabled and buffer holds data.
// - overrun, framing, parity errors flagged, sum flag on any.
module usp_uart
  import usp_pkg::*;
#(
  parameter bit CH1_ROUTING = 1'b0        // 0: single locations, 1: coded
)(
  input  wire logic        hclk,           // system clock
  input  wire logic        hresetn,        // async reset, active low
  input  wire logic        hsel,           // slave select
  input  wire logic [31:0] haddr,          // byte address
  input  wire logic [1:0]  htrans,         // transfer type
  input  wire logic        hwrite,         // write when high
  input  wire logic [2:0]  hsize,          // word only
  input  wire logic [31:0] hwdata,         // write data
  input  wire logic        hready,         // bus ready
  output logic             hreadyout,      // always ready
  output logic             hresp,          // always okay
  output logic [31:0]      hrdata,         // read data
  input  wire logic        fc_tick,        // slow clock enable
  input  wire logic [1:0]  serial_in_pin,  // input pin levels
  input  wire logic [1:0]  in_pin_dir,     // 1 = pin is output
  input  wire logic [2:0]  bit_clock_pin,  // clock pin levels
  input  wire logic [2:0]  clock_pin_dir,  // 1 = pin is output
  output logic [1:0]       serial_out_pin, // output pin levels
  output logic [1:0]       serial_out_oe,  // output pin drive enables
  output logic             tx_request,     // transmit request pulse
  output logic             rx_request      // receive request pulse
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        dp_wr;
    logic [7:0]  dp_addr;
    logic [31:0] rdata;
    usp_mode_s   mode;
    usp_ctl0_s   ctl0;
    usp_ctl1_s   ctl1;
    usp_route_s  route;
    logic [7:0]  brg;
    logic [7:0]  brg_cnt;
    logic [8:0]  txbuf;
    usp_rxbuf_s  rxbuf;
    logic [4:0]  pre;
    logic        ext_prev;
    logic        tick16;
    logic        tx_req;
    logic        rx_req;
  } usp_top_s;

  usp_top_s q;
  usp_top_s d;

  logic               uart_on;
  logic [3:0]         nd;
  usp_frame_s         frame;
  logic [3:0]         rx_len;
  logic               tx_line;
  logic               tx_busy;
  logic               tx_done;
  logic               tx_start;
  logic [FRAME_W-1:0] rx_bits;
  logic               rx_done;
  logic               rx_on;
  logic [1:0]         out_hit;
  logic [1:0]         in_hit;
  logic [2:0]         clk_hit;
  logic               rx_line;
  logic               ext_level;
  logic               ext_on;

  // ----------------------------------------------------------------
  // mode decode and pin routing
  // ----------------------------------------------------------------
  function automatic logic loc_hit(input logic [1:0] sel, input int unsigned loc);
    if (CH1_ROUTING)
      loc_hit = (sel == 2'(loc + 1));
    else
      loc_hit = (loc == 0) && sel[0];
  endfunction : loc_hit

  always_comb
  begin
    uart_on = 1'b1;
    nd      = LEN_8;
    case (q.mode.serial_mode_field)
      MODE_7BIT: nd = LEN_7;
      MODE_8BIT: nd = LEN_8;
      MODE_9BIT: nd = LEN_9;
      default:   uart_on = 1'b0;
    endcase
  end

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_loc
      if (gi < 2)
      begin : g_io
        assign out_hit[gi] = loc_hit(q.route.out_sel, gi);
        assign in_hit[gi]  = loc_hit(q.route.in_sel, gi) && !in_pin_dir[gi];
        // released while idle high under open drain, so a wired line can be pulled low
        assign serial_out_oe[gi]  = out_hit[gi] && uart_on &&
                                    (!q.ctl0.open_drain_select || !tx_line);
        assign serial_out_pin[gi] = tx_line;
      end
      assign clk_hit[gi] = loc_hit(q.route.clock_sel, gi) && !clock_pin_dir[gi];
    end
  endgenerate

  assign rx_line   = |(in_hit & serial_in_pin);
  assign ext_level = |(clk_hit & bit_clock_pin);
  assign ext_on    = q.mode.bit_clock_source_sel && (|clk_hit);
  assign rx_on     = uart_on && q.ctl1.rx_enable && (|in_hit);
  assign tx_start  = uart_on && q.ctl1.tx_enable && !q.ctl1.tx_buffer_empty
                     && !tx_busy;

  // ----------------------------------------------------------------
  // frame build
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [8:0] ch;
    ch = q.txbuf;
    if ((nd == LEN_8) && q.ctl0.bit_order_select)
      for (int k = 0; k < 8; k++)
        ch[k] = q.txbuf[7 - k];
    frame.bits    = '1;
    frame.bits[0] = 1'b0;
    for (int k = 0; k < 9; k++)
      if (k < int'(nd))
        frame.bits[k + 1] = ch[k];
    if (q.mode.parity_enable)
      frame.bits[nd + 4'h1] = ~(^(ch & ~(9'h1FF << nd))) ^
                              q.mode.parity_odd_even;
    frame.len = 4'h2 + nd + {3'h0, q.mode.parity_enable}
                + {3'h0, q.mode.stop_bit_count};
    rx_len    = frame.len - 4'h1;
  end

  usp_tx u_tx (
    .clk    (hclk),
    .rst_n  (hresetn),
    .tick16 (q.tick16),
    .start  (tx_start),
    .frame  (frame),
    .line   (tx_line),
    .busy   (tx_busy),
    .done   (tx_done)
  );

  usp_rx u_rx (
    .clk     (hclk),
    .rst_n   (hresetn),
    .tick16  (q.tick16),
    .enable  (rx_on),
    .line_in (rx_line),
    .len     (rx_len),
    .data    (rx_bits),
    .done    (rx_done)
  );

  // ----------------------------------------------------------------
  // registers, clocking and flags
  // ----------------------------------------------------------------
  always_comb
  begin
    logic               src_tick;
    logic [FRAME_W-1:0] raw;
    logic [8:0]         ch;
    logic               pbit;
    logic               stop_ok;
    logic [3:0]         sp;
    src_tick = 1'b0;
    raw      = '0;
    ch       = '0;
    pbit     = 1'b0;
    stop_ok  = 1'b1;
    sp       = '0;
    d        = q;
    d.tx_req = 1'b0;
    d.rx_req = 1'b0;
    d.tick16 = 1'b0;

    // prescaler and divider
    d.pre      = q.pre + 5'h1;
    d.ext_prev = ext_level;
    case (q.ctl0.divider_count_source)
      CS_F1:   src_tick = 1'b1;
      CS_F8:   src_tick = (q.pre[2:0] == PRE8_LAST);
      CS_F32:  src_tick = (q.pre == PRE32_LAST);
      default: src_tick = fc_tick;
    endcase
    if (q.mode.bit_clock_source_sel)
      src_tick = ext_on && ext_level && !q.ext_prev;
    if (src_tick)
    begin
      if (q.brg_cnt == 8'h00)
      begin
        d.brg_cnt = q.brg;
        d.tick16  = 1'b1;
      end
      else
        d.brg_cnt = q.brg_cnt - 8'h01;
    end

    // bus address phase: reads answer now, with their side effects
    d.dp_wr = 1'b0;
    if (hsel && hready && htrans[1])
    begin
      d.dp_wr   = hwrite;
      d.dp_addr = haddr[7:0];
      if (!hwrite)
      begin
        d.rdata = 32'h0000_0000;
        case (haddr[7:0])
          OFS_RXBUF:
          begin
            d.rdata[15:0] = q.rxbuf;
            d.rdata[8:0]  = q.rxbuf.data & ~(9'h1FF << nd);
            d.rdata[15]   = q.rxbuf.overrun_flag | q.rxbuf.parity_error_flag
                            | q.rxbuf.framing_error_flag;
            d.rxbuf.parity_error_flag  = 1'b0;
            d.rxbuf.framing_error_flag = 1'b0;
            d.ctl1.rx_complete         = 1'b0;
          end
          OFS_MODE:  d.rdata[7:0] = q.mode;
          OFS_CTL0:
          begin
            d.rdata[7:0] = q.ctl0;
            d.rdata[3]   = !tx_busy;
          end
          OFS_CTL1:  d.rdata[7:0] = q.ctl1;
          OFS_ROUTE: d.rdata[7:0] = q.route;
          default:   d.rdata = 32'h0000_0000;
        endcase
      end
    end

    // transmit load; a write in the same cycle lands after it and is kept
    if (tx_start)
    begin
      d.ctl1.tx_buffer_empty = 1'b1;
      d.tx_req = !q.ctl1.tx_irq_source_select;
    end
    if (tx_done && q.ctl1.tx_irq_source_select)
      d.tx_req = 1'b1;

    // bus data phase writes
    if (q.dp_wr)
    begin
      case (q.dp_addr)
        OFS_TXBUF:
        begin
          d.txbuf = hwdata[8:0];
          d.ctl1.tx_buffer_empty = 1'b0;
        end
        OFS_BRG:   d.brg  = hwdata[7:0];
        OFS_MODE:  d.mode = {1'b0, hwdata[6:0]};
        OFS_CTL0:
        begin
          d.ctl0 = hwdata[7:0];
          d.ctl0.rsv4 = 1'b0;
          d.ctl0.rsv2 = 1'b0;
          d.ctl0.shift_reg_empty_flag = 1'b1;
        end
        OFS_CTL1:
        begin
          d.ctl1.tx_enable            = hwdata[0];
          d.ctl1.rx_enable            = hwdata[2];
          d.ctl1.tx_irq_source_select = hwdata[4];
          d.ctl1.continuous_rx_mode   = hwdata[5];
        end
        OFS_ROUTE: d.route = {2'h0, hwdata[5:0]};
        default:   d.brg = q.brg;
      endcase
    end

    // overrun stays until the receiver is switched off
    if (!rx_on && !(q.ctl1.rx_enable && uart_on))
      d.rxbuf.overrun_flag = 1'b0;

    // receive completion; applied last so a set beats a same-cycle clear
    if (rx_done)
    begin
      raw = rx_bits >> (4'(FRAME_W) - rx_len);
      ch  = raw[8:0] & ~(9'h1FF << nd);
      sp  = nd + {3'h0, q.mode.parity_enable};
      pbit = raw[nd];
      stop_ok = raw[sp] && (!q.mode.stop_bit_count || raw[sp + 4'h1]);
      if ((nd == LEN_8) && q.ctl0.bit_order_select)
        for (int k = 0; k < 8; k++)
          ch[k] = raw[7 - k];
      if (d.ctl1.rx_complete)
        d.rxbuf.overrun_flag = 1'b1;
      d.rxbuf.data = ch;
      d.rxbuf.framing_error_flag = !stop_ok;
      d.rxbuf.parity_error_flag  = q.mode.parity_enable &&
        ((^ch ^ pbit) == q.mode.parity_odd_even);
      d.ctl1.rx_complete = 1'b1;
      d.rx_req = 1'b1;
    end
    d.rxbuf.sum = d.rxbuf.overrun_flag | d.rxbuf.framing_error_flag
                  | d.rxbuf.parity_error_flag;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      q       <= '0;
      q.mode  <= RST_MODE;
      q.ctl0  <= RST_CTL0;
      q.ctl1  <= RST_CTL1;
      q.route <= RST_ROUTE;
    end
    else
      q <= d;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign hrdata     = q.rdata;
  assign tx_request = q.tx_req;
  assign rx_request = q.rx_req;

endmodule : usp_uart
`default_nettype wire

// ---- bench/usp_uart_sva.sv ----
// port checker for the uart channel, bound to the channel top
`timescale 1ns/1ns
`default_nettype none
module usp_uart_sva
(
  input wire logic        hclk,           // system clock
  input wire logic        hresetn,        // async reset, active low
  input wire logic        hsel,           // slave select
  input wire logic [1:0]  htrans,         // transfer type
  input wire logic        hwrite,         // write when high
  input wire logic        hready,         // bus ready
  input wire logic        hreadyout,      // slave ready
  input wire logic        hresp,          // response
  input wire logic [31:0] hrdata,         // read data
  input wire logic [1:0]  serial_out_pin, // output levels
  input wire logic        tx_request,     // transmit request
  input wire logic        rx_request      // receive request
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic rd_take;
  logic wr_take;
  assign rd_take = hsel && hready && htrans[1] && !hwrite;
  assign wr_take = hsel && hready && htrans[1] && hwrite;
  // a bit lasts sixteen cycles even at the fastest divider, so eight is a safe floor
  sequence line_fall_s; $fell(serial_out_pin[0]); endsequence
  sequence line_low_s; !serial_out_pin[0] [*8]; endsequence
  ready_always_a: assert property (hreadyout) else $error("slave stalled the bus");
  resp_okay_a: assert property (!hresp) else $error("error response seen");
  bit_hold_a: assert property (line_fall_s |-> line_low_s)
    else $error("low bit shorter than eight cycles");
  pins_agree_a: assert property (serial_out_pin[0] == serial_out_pin[1])
    else $error("output locations disagree");
  rdata_hold_a: assert property ($changed(hrdata) |-> $past(rd_take))
    else $error("read data moved without a read");
  write_quiet_a: assert property (wr_take |=> $stable(hrdata))
    else $error("write disturbed read data");
  tx_pulse_a: assert property (tx_request |=> !tx_request)
    else $error("transmit request longer than one cycle");
  rx_pulse_a: assert property (rx_request |=> !rx_request)
    else $error("receive request longer than one cycle");
endmodule : usp_uart_sva
bind usp_uart usp_uart_sva u_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .serial_out_pin(serial_out_pin),
  .tx_request(tx_request), .rx_request(rx_request));
`default_nettype wire

// ---- bench/usp_peer.sv ----
// remote serial peer: sends frames to the channel and captures what it sends
`timescale 1ns/1ns
`default_nettype none
module usp_peer
(
  input  wire logic hclk,    // shared clock
  input  wire logic tx_line, // level from the channel
  output logic      rx_line  // level to the channel
);
  localparam int BIT_T = 16; // cycles per bit at divider 0 with f1
  initial rx_line = 1'h1;
  // start bit, then n bits lsb first, then back to the mark level
  task automatic send(input logic [12:0] b, input int n);
    rx_line <= 1'h0;
    repeat (BIT_T) @(posedge hclk);
    for (int i = 0; i < n; i++)
    begin
      rx_line <= b[i];
      repeat (BIT_T) @(posedge hclk);
    end
    rx_line <= 1'h1;
  endtask : send
  // samples mid bit; ok drops if no start bit shows within the bound
  task automatic recv(input int n, output logic [12:0] b, output bit ok);
    int t;
    b = '0;
    t = 0;
    while (tx_line !== 1'h0 && t < 2000)
    begin
      @(posedge hclk);
      t++;
    end
    ok = (t < 2000);
    repeat (BIT_T / 2) @(posedge hclk);
    for (int i = 0; i < n; i++)
    begin
      repeat (BIT_T) @(posedge hclk);
      b[i] = tx_line;
    end
  endtask : recv
endmodule : usp_peer
`default_nettype wire

// ---- bench/tb_uart_mode_frame_and_pins.sv ----
// self-checking bench for the uart channel: registers, idle pin, transmit, receive
`timescale 1ns/1ns
`default_nettype none
module tb_uart_mode_frame_and_pins
  import usp_pkg::*;
;
  logic        hclk = 1'h0;
  logic        hresetn = 1'h0;
  logic        hsel = 1'h0;
  logic        hwrite = 1'h0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  wire logic        hready, hresp, tx_request, rx_request, peer_rx, line;
  wire logic [31:0] hrdata;
  wire logic [1:0]  out_pin, out_oe;
  int mismatches = 0;
  int n_checks = 0;
  int n_tx_req = 0;
  int n_rx_req = 0;
  logic [1:0]  in_dir = 2'h0;
  always #10 hclk = ~hclk;
  // request pulses are counted here and compared at the end of the transmit and receive scenarios
  always @(posedge hclk)
  begin
    if (tx_request === 1'h1) n_tx_req++;
    if (rx_request === 1'h1) n_rx_req++;
  end
  // released output floats to the pull-up level
  assign line = out_oe[0] ? out_pin[0] : 1'h1;
  usp_uart #(.CH1_ROUTING(1'h0)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .fc_tick(1'h0),
    .serial_in_pin({2{peer_rx}}), .in_pin_dir(in_dir), .bit_clock_pin(3'h7),
    .clock_pin_dir(3'h0), .serial_out_pin(out_pin), .serial_out_oe(out_oe),
    .tx_request(tx_request), .rx_request(rx_request));
  usp_peer peer (.hclk(hclk), .tx_line(line), .rx_line(peer_rx));
  // ----------------------------------------------------------------
  // bus and comparison helpers
  // ----------------------------------------------------------------
  task automatic test_done(input bit hang);
    if (hang) mismatches++;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // entered just after a rising edge; returns just after the data phase ends
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int t;
    t = 0;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    hsel <= 1'h1;
    do @(posedge hclk); while (hready !== 1'h1 && ++t < 50);
    htrans <= 2'h0;
    hsel <= 1'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'h1 && ++t < 50);
    rd = hrdata;
    if (t >= 50) test_done(1'h1);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'h1, a, d, x);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'h0, a, 32'h0, x);
    chk(x, e);
  endtask : rdc
  task automatic pin_chk(input logic [3:0] e);
    @(negedge hclk);
    chk(32'({out_oe, out_pin}), 32'(e));
    @(posedge hclk);
  endtask : pin_chk
  task automatic t_regs();
    pin_chk(4'h3);
    rdc(OFS_MODE, 32'(RST_MODE));
    rdc(OFS_CTL0, 32'(RST_CTL0));
    rdc(OFS_CTL1, 32'(RST_CTL1));
    rdc(OFS_ROUTE, 32'(RST_ROUTE));
    rdc(OFS_BRG, 32'h0);
    rdc(8'h1C, 32'h0);
  endtask : t_regs
  task automatic t_idle();
    wr(OFS_ROUTE, 32'h5);
    wr(OFS_MODE, 32'(MODE_8BIT));
    pin_chk(4'h7);
    wr(OFS_CTL0, 32'h20);
    pin_chk(4'h3);
    wr(OFS_CTL0, 32'h0);
    wr(OFS_ROUTE, 32'h4);
    pin_chk(4'h3);
    wr(OFS_ROUTE, 32'h5);
  endtask : t_idle
  // entry: mode, control 0, length, data as it arrives lsb first
  task automatic t_tx();
    logic [31:0] cfg [4] = '{32'h0400_7034, 32'h0500_80B4, 32'h0580_802D, 32'h0600_91B4};
    logic [12:0] b;
    bit ok;
    wr(OFS_BRG, 32'h0);
    foreach (cfg[i])
    begin
      wr(OFS_CTL1, 32'h0);
      wr(OFS_MODE, 32'(cfg[i][31:24]));
      wr(OFS_CTL0, 32'(cfg[i][23:16]));
      wr(OFS_TXBUF, 32'h1B4);
      pin_chk(4'h7);
      rdc(OFS_CTL1, 32'h0);
      fork
        peer.recv(int'(cfg[i][15:12]) + 1, b, ok);
        wr(OFS_CTL1, 32'h1);
      join
      if (!ok) test_done(1'h1);
      chk(32'(b), (32'h1 << cfg[i][15:12]) | 32'(cfg[i][8:0]));
      repeat (16) @(posedge hclk);
      rdc(OFS_CTL0, 32'(cfg[i][23:16]) | 32'h8);
      rdc(OFS_CTL1, 32'h3);
    end
    chk(32'(n_tx_req), 32'h4);
  endtask : t_tx
  // entry: mode, bit count, frame after the start bit, expected receive buffer
  task automatic t_rx();
    logic [63:0] fr [5] = '{64'h0590_015A_0000_005A, 64'h65A0_035A_0000_C05A,
      64'h0590_005A_0000_A05A, 64'h4490_01DA_0000_005A, 64'h06A0_035A_0000_015A};
    wr(OFS_CTL1, 32'h0);
    peer.send(13'h15A, 9);
    rdc(OFS_CTL1, 32'h2);
    wr(OFS_CTL1, 32'h4);
    foreach (fr[i])
    begin
      wr(OFS_MODE, 32'(fr[i][63:56]));
      peer.send(fr[i][44:32], int'(fr[i][55:52]));
      @(posedge hclk);
      rdc(OFS_CTL1, 32'hE);
      rdc(OFS_RXBUF, 32'(fr[i][15:0]));
      rdc(OFS_CTL1, 32'h6);
    end
    // receive pin turned to output: its level must be ignored
    in_dir <= 2'h1;
    peer.send(13'h15A, 9);
    rdc(OFS_CTL1, 32'h6);
    chk(32'(n_rx_req), 32'h5);
  endtask : t_rx
  initial
  begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    t_regs();
    t_idle();
    t_tx();
    t_rx();
    test_done(1'h0);
  end
endmodule : tb_uart_mode_frame_and_pins
`default_nettype wire
